// ==== hdl/dmc_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the pattern readout block
`ifndef DMC_REGS_VH
`define DMC_REGS_VH
`define DMC_OFF_CMD 12'h000
`define DMC_OFF_MODE0 12'h004
`define DMC_OFF_MODE1 12'h008
`define DMC_OFF_MODE2 12'h00C
`define DMC_OFF_MODE3 12'h010
`define DMC_OFF_STAT 12'h014
`define DMC_OFF_DATA 12'h018
`define DMC_CMD_TYPE_LSB 0
`define DMC_CMD_BA_LSB 4
`define DMC_CMD_ADDR_LSB 8
`define DMC_CMD_MRS 2'h1
`define DMC_CMD_RD 2'h2
`define DMC_CMD_WR 2'h3
`define DMC_M3_EN_BIT 2
`define DMC_M3_FS_LSB 0
`define DMC_M0_BL_LSB 0
`define DMC_BL_FIX8 2'h0
`define DMC_BL_OTF 2'h1
`define DMC_BL_FIX4 2'h2
`define DMC_MODE_RST 14'h0000
`define DMC_AL_RST 4'h0
`define DMC_CL_RST 4'h5
`define DMC_PATTERN 8'hAA
`define DMC_MOD_NS 60
`define DMC_MOD_CYC ((`DMC_MOD_NS + 3) / 4)
`endif

// ==== hdl/dmc_pattern_read.v ====
// Pattern readout and mode-register load logic with APB command and status port
`timescale 1ns/10ps
`include "dmc_regs.vh"
module dmc_pattern_read #(
  parameter LANES = 16,
  parameter AW = 14,
  parameter ARRAY_WORDS = 16,
  parameter ALL_LANES = 0
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg [LANES-1:0] dq_out,
  output reg dq_oe,
  output reg pattern_mode
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_BURST = 2'h2;
  localparam [7:0] MOD_CYC = `DMC_MOD_CYC;
  localparam [7:0] PAT = `DMC_PATTERN;

  reg [AW-1:0] mode0_q, mode1_q, mode2_q, mode3_q;
  reg [AW-1:0] pend_val_q;
  reg [1:0] pend_sel_q;
  reg [7:0] mod_cnt_q;
  reg [1:0] state_q;
  reg [4:0] lat_cnt_q;
  reg [2:0] beat_q;
  reg [2:0] last_q;
  reg pat_q;
  reg [LANES-1:0] rd_word_q;
  reg [LANES-1:0] arr_q [0:ARRAY_WORDS-1];
  reg [3:0] col_q;
  reg refused_q;
  reg [LANES-1:0] dq_d;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire cmd_go = wr_acc & (paddr == `DMC_OFF_CMD);
  wire [1:0] cmd_type = pwdata[`DMC_CMD_TYPE_LSB +: 2];
  wire [2:0] cmd_ba = pwdata[`DMC_CMD_BA_LSB +: 3];
  wire [AW-1:0] cmd_addr = pwdata[`DMC_CMD_ADDR_LSB +: AW];
  wire busy = (state_q != ST_IDLE);
  wire pat_en = mode3_q[`DMC_M3_EN_BIT];
  wire [1:0] pat_fs = mode3_q[`DMC_M3_FS_LSB +: 2];
  wire [1:0] bl_mode = mode0_q[`DMC_M0_BL_LSB +: 2];
  wire [4:0] rd_lat = {1'b0, mode1_q[3:0]} + {1'b0, mode2_q[3:0]};

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  function [2:0] last_beat;
    input [1:0] blm;
    input a12;
    begin
      if (blm == `DMC_BL_FIX4)
        last_beat = 3'h3;
      else if (blm == `DMC_BL_OTF && !a12)
        last_beat = 3'h3;
      else
        last_beat = 3'h7;
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode0_q <= `DMC_MODE_RST;
      mode1_q <= {{(AW-4){1'b0}}, `DMC_AL_RST};
      mode2_q <= {{(AW-4){1'b0}}, `DMC_CL_RST};
      mode3_q <= `DMC_MODE_RST;
      pend_val_q <= `DMC_MODE_RST;
      pend_sel_q <= 2'h0;
      mod_cnt_q <= 8'h00;
    end else if (mod_cnt_q != 8'h00) begin
      mod_cnt_q <= mod_cnt_q - 8'h01;
      if (mod_cnt_q == 8'h01) begin
        case (pend_sel_q)
          2'h0: mode0_q <= pend_val_q;
          2'h1: mode1_q <= pend_val_q;
          2'h2: mode2_q <= pend_val_q;
          default: mode3_q <= pend_val_q;
        endcase
      end
    end else if (cmd_go && cmd_type == `DMC_CMD_MRS && cmd_ba[2] == 1'b0 && !busy) begin
      pend_sel_q <= cmd_ba[1:0];
      pend_val_q <= cmd_addr;
      mod_cnt_q <= MOD_CYC;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      lat_cnt_q <= 5'h00;
      beat_q <= 3'h0;
      last_q <= 3'h0;
      pat_q <= 1'b0;
      col_q <= 4'h0;
      refused_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_go && cmd_type == `DMC_CMD_RD) begin
            pat_q <= pat_en & (pat_fs == 2'h0);
            col_q <= cmd_addr[3:0];
            // Bit two picks the nibble of a 4-beat pattern burst, bit 12 picks the on-the-fly burst length
            beat_q <= (pat_en && last_beat(bl_mode, cmd_addr[12]) == 3'h3) ?
                      {cmd_addr[2], 2'h0} : 3'h0;
            last_q <= (pat_en && last_beat(bl_mode, cmd_addr[12]) == 3'h3) ?
                      {cmd_addr[2], 2'h3} : last_beat(bl_mode, cmd_addr[12]);
            lat_cnt_q <= (rd_lat == 5'h00) ? 5'h00 : rd_lat - 5'h01;
            state_q <= ST_WAIT;
          end else if (cmd_go && cmd_type == `DMC_CMD_WR && pat_en) begin
            refused_q <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (lat_cnt_q == 5'h00)
            state_q <= ST_BURST;
          else
            lat_cnt_q <= lat_cnt_q - 5'h01;
        end
        ST_BURST: begin
          if (beat_q == last_q)
            state_q <= ST_IDLE;
          else
            beat_q <= beat_q + 3'h1;
        end
        default: state_q <= ST_IDLE;
      endcase
      if (rd_acc && paddr == `DMC_OFF_STAT)
        refused_q <= 1'b0;
    end
  end

  // Array write path, only with pattern mode off
  always @(posedge pclk) begin
    if (cmd_go && cmd_type == `DMC_CMD_WR && !pat_en && !busy)
      arr_q[cmd_addr[3:0] % ARRAY_WORDS] <= pwdata[31:32-LANES];
  end

  integer i;
  always @* begin
    dq_d = {LANES{1'b0}};
    if (pat_q) begin
      for (i = 0; i < LANES; i = i + 1)
        if (ALL_LANES != 0 || (i % 8) == 0)
          dq_d[i] = PAT[beat_q];
    end else begin
      dq_d = arr_q[(col_q + {1'b0, beat_q}) % ARRAY_WORDS];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_out <= {LANES{1'b0}};
      dq_oe <= 1'b0;
      pattern_mode <= 1'b0;
      rd_word_q <= {LANES{1'b0}};
      prdata <= 32'h00000000;
    end else begin
      dq_oe <= (state_q == ST_BURST);
      dq_out <= (state_q == ST_BURST) ? dq_d : {LANES{1'b0}};
      pattern_mode <= pat_en;
      if (state_q == ST_BURST)
        rd_word_q <= dq_d;
      if (rd_acc) begin
        case (paddr)
          `DMC_OFF_MODE0: prdata <= {{(32-AW){1'b0}}, mode0_q};
          `DMC_OFF_MODE1: prdata <= {{(32-AW){1'b0}}, mode1_q};
          `DMC_OFF_MODE2: prdata <= {{(32-AW){1'b0}}, mode2_q};
          `DMC_OFF_MODE3: prdata <= {{(32-AW){1'b0}}, mode3_q};
          `DMC_OFF_STAT: prdata <= {27'h0000000, refused_q, mod_cnt_q != 8'h00, busy,
                                    pat_en, dq_oe};
          `DMC_OFF_DATA: prdata <= {{(32-LANES){1'b0}}, rd_word_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // dmc_pattern_read

// ==== bench/dmc_monitor.sv ====
// Checker for pattern beats and mode timing
`timescale 1ns/10ps
module dmc_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [15:0] dq_out,
  input wire dq_oe,
  input wire pattern_mode
);
  wire cmd = psel && penable && pwrite && paddr == 12'h000;
  wire rd = cmd && pwdata[1:0] == 2'h2 && !dq_oe;
  wire ld3 = cmd && pwdata[1:0] == 2'h1 && pwdata[6:4] == 3'h3;
  wire pb = dq_oe && pattern_mode;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_lane_low: assert property (pb |-> {dq_out[15:9], dq_out[7:1]} == 14'h0000)
    else $error("side lane high");
  a_first_zero: assert property (pattern_mode && $rose(dq_oe) |-> !dq_out[0])
    else $error("first beat wrong");
  a_beat_alt: assert property (pb && $past(dq_oe) |-> dq_out[0] != $past(dq_out[0]))
    else $error("pattern not alternating");
  a_min_len: assert property ($rose(dq_oe) |=> dq_oe[*3])
    else $error("burst too short");
  a_max_len: assert property (dq_oe[*8] |=> !dq_oe)
    else $error("burst too long");
  a_read_lat: assert property (rd |=> !dq_oe[*5] ##[1:4] dq_oe)
    else $error("read latency wrong");
  a_enter_lat: assert property (ld3 && pwdata[10] && !pattern_mode
    |=> !pattern_mode[*8] ##5 !pattern_mode ##[1:4] pattern_mode) else $error("entry timing");
  a_exit_lat: assert property (ld3 && !pwdata[10] && pattern_mode
    |=> pattern_mode[*8] ##5 pattern_mode ##[1:4] !pattern_mode) else $error("exit timing");
endmodule // dmc_monitor
bind dmc_pattern_read dmc_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .dq_out(dq_out),
  .dq_oe(dq_oe), .pattern_mode(pattern_mode));

// ==== bench/dmc_dq_sink.sv ====
// Controller-side capture of prime lane beats
`timescale 1ns/10ps
module dmc_dq_sink (
  input wire pclk,
  input wire presetn,
  input wire dq_oe,
  input wire [15:0] dq_out,
  output reg [7:0] cap_q,
  output reg [3:0] cnt_q
);
  reg oe_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= 1'b0;
      cap_q <= 8'h00;
      cnt_q <= 4'h0;
    end else begin
      oe_q <= dq_oe;
      if (dq_oe) begin
        cap_q[oe_q ? cnt_q[2:0] : 3'h0] <= dq_out[0];
        cnt_q <= oe_q ? cnt_q + 4'h1 : 4'h1;
      end
    end
  end
endmodule // dmc_dq_sink

// ==== bench/tb_top.sv ====
// Self-checking bench for the pattern readout block
`timescale 1ns/10ps
`include "dmc_regs.vh"
module tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, a12, a2;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rdv, r;
  reg [1:0] bl;
  reg [7:0] m;
  integer seed = 32'h0d7a, n_mismatch = 0, cmp_count = 0, i, k;
  wire [31:0] prdata;
  wire pready, pslverr, dq_oe, pattern_mode;
  wire [15:0] dq_out;
  wire [7:0] cap;
  wire [3:0] cnt;
  dmc_pattern_read i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dq_out(dq_out), .dq_oe(dq_oe), .pattern_mode(pattern_mode));
  dmc_dq_sink i_sink (.pclk(pclk), .presetn(presetn), .dq_oe(dq_oe), .dq_out(dq_out),
    .cap_q(cap), .cnt_q(cnt));
  initial forever #2 pclk = ~pclk;
  function [3:0] exp_len(input [1:0] b, input c);
    exp_len = (b == `DMC_BL_FIX4 || (b == `DMC_BL_OTF && !c)) ? 4'h4 : 4'h8;
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk) rdv = prdata;
  endtask
  task cmd(input [1:0] t, input [2:0] ba, input [13:0] ad);
    r = $random(seed);
    apb(`DMC_OFF_CMD, 1'b1, {r[31:22], ad, 1'b0, ba, 2'b00, t});
  endtask
  task ld(input [2:0] ba, input [13:0] ad);
    cmd(`DMC_CMD_MRS, ba, ad);
    repeat (20) @(posedge pclk);
  endtask
  task burst;
    r = $random(seed);
    cmd(`DMC_CMD_RD, r[2:0], {r[13], a12, r[11:3], a2, 2'b00});
    k = 0;
    while (dq_oe !== 1'b1 && k < 40) begin
      @(posedge pclk);
      k = k + 1;
    end
    chk(k < 40, 1'b1);
    while (dq_oe === 1'b1) @(posedge pclk);
    repeat (3) @(posedge pclk);
    m = exp_len(bl, a12) == 4'h4 ? 8'h0F : 8'hFF;
    chk(cnt, exp_len(bl, a12));
    chk(cap & m, `DMC_PATTERN & m);
  endtask
  task final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h0FC, 1'b0, 32'h0);
    chk(rdv, 32'h0);
    cmd(`DMC_CMD_WR, 3'h0, 14'h0005);
    apb(`DMC_OFF_STAT, 1'b0, 32'h0);
    chk(rdv[4], 1'b0);
    chk(pslverr, 1'b0);
    for (i = 0; i < 5; i = i + 1) begin
      bl = i == 0 ? `DMC_BL_FIX8 : (i < 3 ? `DMC_BL_OTF : `DMC_BL_FIX4);
      a12 = i[0] || i == 4;
      a2 = i == 2 || i == 4;
      if (!a2) begin
        if (i > 0)
          ld(3'h3, 14'h0000);
        ld(3'h0, {12'h000, bl});
        apb(`DMC_OFF_MODE0, 1'b0, 32'h0);
        chk(rdv, {30'h0, bl});
        ld(3'h3, 14'h0004);
        chk(pattern_mode, 1'b1);
      end
      repeat (2) burst;
    end
    apb(`DMC_OFF_DATA, 1'b0, 32'h0);
    chk(rdv, 32'h00000101);
    cmd(`DMC_CMD_WR, 3'h0, 14'h0003);
    apb(`DMC_OFF_STAT, 1'b0, 32'h0);
    chk(rdv[4], 1'b1);
    apb(`DMC_OFF_STAT, 1'b0, 32'h0);
    chk(rdv[4], 1'b0);
    ld(3'h3, 14'h0000);
    chk(pattern_mode, 1'b0);
    final_report;
  end
endmodule // tb_top
